// *** rtl/sbg_core.sv ***
// baud divider, three-sample receive front end and receive control/status
// assumes a classic Wishbone master on the same clock; rx_pin is asynchronous
// Notes on behaviour
// RULE_01 - one 8-bit baud divider serves async and sync operation
// RULE_02 - divider free-runs, period set by divider register value
// RULE_03 - in async mode high-speed select changes the baud rate
// RULE_04 - in sync mode high-speed select is ignored
// RULE_05 - bit clock from divider only as master; slave uses external clock
// RULE_06 - any divider register write clears the divider timer at once
// RULE_07 - receive pin sampled three times, majority gives the level
// RULE_08 - async baud is fosc/(64(x+1)) low speed, fosc/(16(x+1)) high
// RULE_09 - sync master bit clock is fosc/(4(x+1)), x from 0 to 255
// RULE_10 - mode select 0 is async, 1 is sync, choosing the formula
// RULE_11 - overrun set on full buffer, cleared by continuous-receive off
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module sbg_core
   import sbg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial pins
   input wire logic rx_pin,
   input wire logic ext_bit_clk,
   // bit clock and sampled level
   output logic bit_tick,
   output logic rx_level,
   // received word stream
   output sbg_word_t rx_word,
   output logic rx_valid,
   input wire logic rx_ready
);
   // ==========================================================
   // bus decode
   logic ack_q;
   logic [7:0] tx_ctrl_q, rx_ctrl_q, div_q;
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
   wire wr_tx = bus_wr & (wb_adr_i == SBG_ADDR_TX_CTRL);
   wire wr_rx = bus_wr & (wb_adr_i == SBG_ADDR_RX_CTRL);
   wire wr_div = bus_wr & (wb_adr_i == SBG_ADDR_DIVIDER);
   wire rd_data = bus_req & ~wb_we_i & (wb_adr_i == SBG_ADDR_DATA);
   wire sync_mode = tx_ctrl_q[SBG_TX_SYNC_MODE];
   wire high_speed = tx_ctrl_q[SBG_TX_HIGH_SPEED];
   wire clk_master = tx_ctrl_q[SBG_TX_CLK_MASTER];
   wire pins_en = rx_ctrl_q[SBG_RX_PINS_EN];
   wire cont_en = rx_ctrl_q[SBG_RX_CONT_EN];

   // ==========================================================
   // baud divider: prescaler then 8-bit reload counter
   logic [5:0] pre_q;
   logic [7:0] cnt_q;
   // sync ignores high speed; mode bit picks the formula
   wire [5:0] pre_top = sync_mode ? SBG_PRE_SYNC : // RULE_04 RULE_09 RULE_10
                        (high_speed ? SBG_PRE_HIGH : SBG_PRE_LOW); // RULE_03
   wire pre_wrap = (pre_q >= pre_top);
   wire div_wrap = pre_wrap & (cnt_q >= div_q); // RULE_02 RULE_08
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 6'h00;
         cnt_q <= 8'h00;
      end else if (wr_div || !pins_en) begin
         pre_q <= 6'h00; // RULE_06
         cnt_q <= 8'h00;
      end else begin
         pre_q <= pre_wrap ? 6'h00 : pre_q + 6'h01;
         if (pre_wrap) cnt_q <= div_wrap ? 8'h00 : cnt_q + 8'h01; // RULE_01
      end
   end

   // a disabled port parks the divider so it restarts from zero
   pins_off_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      !pins_en |=> (cnt_q == 8'h00 && pre_q == 6'h00)) // RULE_02
      else $error("divider runs with port off");

   // a mode change may overshoot the new top for one cycle only
   pre_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(wr_tx) |-> pre_q <= pre_top) // RULE_08
      else $error("prescaler past its top");

   // the divider only wraps on a prescaler wrap at the divider value
   wrap_on_count_a: assert property (@(posedge clk) disable iff (!rst_n)
      div_wrap |-> (pre_wrap && cnt_q == div_q)) // RULE_09
      else $error("divider wraps off count");

   // ==========================================================
   // external bit clock: two-flop sync then edge detect
   logic [2:0] ext_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ext_q <= 3'h0;
      else ext_q <= {ext_q[1:0], ext_bit_clk};
   end
   wire ext_rise = ext_q[1] & ~ext_q[2];
   // slave takes the external edge instead of the divider
   wire tick_w = (sync_mode && !clk_master) ? ext_rise : div_wrap; // RULE_05
   assign bit_tick = tick_w & pins_en;

   // no bit clock at all while the port pins are released
   tick_gated_a: assert property (@(posedge clk) disable iff (!rst_n)
      !pins_en |-> !bit_tick) // RULE_05
      else $error("tick with port off");

   // a slave follows the external edge, never its own divider
   tick_slave_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pins_en && sync_mode && !clk_master) |-> bit_tick == ext_rise) // RULE_05
      else $error("slave tick not external");

   // ==========================================================
   // receive pin: synchroniser, then three-sample majority
   logic [1:0] rx_sync_q;
   logic [2:0] smp_q;
   logic lvl_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync_q <= 2'h3;
         smp_q <= 3'h7;
         lvl_q <= 1'b1;
      end else begin
         rx_sync_q <= {rx_sync_q[0], rx_pin};
         if (pre_wrap) smp_q <= {smp_q[1:0], rx_sync_q[1]};
         lvl_q <= (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) |
                  (smp_q[1] & smp_q[2]); // RULE_07
      end
   end
   assign rx_level = lvl_q;

   // three low samples must give a low level
   majority_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(smp_q) == 3'h0 |-> !lvl_q) // RULE_07
      else $error("majority low lost");

   // samples only move on a prescaler wrap
   sample_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !pre_wrap |=> $stable(smp_q)) // RULE_07
      else $error("sample taken off wrap");

   // ==========================================================
   // minimal async deserialiser: start, 8/9 data bits, stop
   logic [3:0] bit_q;
   logic [8:0] shf_q;
   logic busy_q;
   wire nine = rx_ctrl_q[SBG_RX_NINE_BIT];
   wire [3:0] last_bit = nine ? 4'd10 : 4'd9;
   wire frame_end = busy_q & bit_tick & (bit_q == last_bit);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_q <= 4'h0;
         shf_q <= 9'h000;
         busy_q <= 1'b0;
      end else if (!busy_q) begin
         busy_q <= bit_tick & cont_en & ~lvl_q;
         bit_q <= 4'h1;
      end else if (bit_tick) begin
         if (bit_q == last_bit) busy_q <= 1'b0;
         else shf_q <= {lvl_q, shf_q[8:1]};
         bit_q <= bit_q + 4'h1;
      end
   end
   wire [8:0] got = nine ? shf_q : {1'b0, shf_q[8:1]};

   // ==========================================================
   // two-entry receive buffer
   sbg_word_t buf_q [2];
   logic [1:0] cnt_b_q;
   logic rd_ptr_q, wr_ptr_q;
   wire buf_full = (cnt_b_q == 2'd2);
   wire push = frame_end & ~buf_full;
   wire pop = rx_valid & (rx_ready | rd_data);
   assign rx_valid = (cnt_b_q != 2'd0);
   assign rx_word = buf_q[rd_ptr_q];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_b_q <= 2'd0;
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         buf_q[0] <= '0;
         buf_q[1] <= '0;
      end else begin
         if (push) buf_q[wr_ptr_q] <= sbg_word_t'(got);
         wr_ptr_q <= wr_ptr_q ^ push;
         rd_ptr_q <= rd_ptr_q ^ pop;
         cnt_b_q <= cnt_b_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // the fill count never passes the two entries
   buf_count_a: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_b_q <= 2'd2)
      else $error("buffer count overflow");

   // a stalled head word must not change under the receiver
   head_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_valid && !pop) |=> (rx_valid && $stable(rx_word)))
      else $error("head word changed while stalled");

   // ==========================================================
   // control registers and error flags; a set beats a clear
   wire ovr_set = frame_end & buf_full;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ctrl_q <= SBG_TX_RESET;
         rx_ctrl_q <= SBG_RX_RESET;
         div_q <= SBG_DIV_RESET;
      end else begin
         if (wr_tx) tx_ctrl_q <= wb_dat_i[7:0];
         if (wr_div) div_q <= wb_dat_i[7:0];
         if (wr_rx) rx_ctrl_q[7:3] <= wb_dat_i[7:3];
         if (ovr_set) rx_ctrl_q[SBG_RX_OVERRUN] <= 1'b1; // RULE_11
         else if (!cont_en) rx_ctrl_q[SBG_RX_OVERRUN] <= 1'b0;
         if (push) begin
            rx_ctrl_q[SBG_RX_FRAME_ERR] <= ~lvl_q; // RULE_11
            rx_ctrl_q[SBG_RX_NINTH] <= got[8];
         end
      end
   end

   // overrun sticks while continuous receive stays on
   overrun_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_ctrl_q[SBG_RX_OVERRUN] && cont_en) |=> rx_ctrl_q[SBG_RX_OVERRUN])
      else $error("overrun flag lost"); // RULE_11

   // turning continuous receive off clears overrun
   overrun_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!cont_en && !ovr_set) |=> !rx_ctrl_q[SBG_RX_OVERRUN]) // RULE_11
      else $error("overrun flag not cleared");

   // each stored byte rewrites the framing flag from its stop bit
   frame_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      push |=> rx_ctrl_q[SBG_RX_FRAME_ERR] == !$past(lvl_q)) // RULE_11
      else $error("framing flag wrong");

   // ==========================================================
   // read mux and single-cycle ack
   wire [7:0] rd_sel = (wb_adr_i == SBG_ADDR_TX_CTRL) ? tx_ctrl_q :
                       (wb_adr_i == SBG_ADDR_RX_CTRL) ? rx_ctrl_q :
                       (wb_adr_i == SBG_ADDR_DIVIDER) ? div_q :
                       (wb_adr_i == SBG_ADDR_DATA) ? rx_word.data : 8'h00;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         if (bus_req) wb_dat_o <= {24'h000000, rd_sel};
      end
   end
   assign wb_ack_o = ack_q;

   // every taken request is answered in the next cycle
   ack_after_req_a: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req |=> wb_ack_o)
      else $error("request not acknowledged");

   // registers sit in the low lane, the rest reads zero
   upper_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read lanes not zero");

   // ==========================================================
   // checks
   reset_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_div |=> (cnt_q == 8'h00 && pre_q == 6'h00)) // RULE_06
      else $error("divider not cleared on write");
   sync_presc_a: assert property (@(posedge clk) disable iff (!rst_n)
      sync_mode |-> pre_top == 6'h03) // RULE_04
      else $error("sync prescale wrong");
   async_presc_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sync_mode |-> pre_top == (high_speed ? 6'h0F : 6'h3F)) // RULE_03
      else $error("async prescale wrong");
   overrun_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      ovr_set |=> rx_ctrl_q[SBG_RX_OVERRUN]) // RULE_11
      else $error("overrun flag not set");
   majority_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(smp_q) == 3'h7 |-> lvl_q) // RULE_07
      else $error("majority high lost");
   tick_src_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
      (pins_en && !(sync_mode && !clk_master)) |-> bit_tick == div_wrap)
      else $error("tick source wrong");
   div_bound_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
      !wr_div && !$past(wr_div) |-> cnt_q <= div_q || $changed(div_q))
      else $error("counter exceeds divider");
   ack_once_a: assert property (@(posedge clk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule : sbg_core

// *** rtl/sbg_pkg.sv ***
// package for the serial baud generator and receive sampling front end
// assumes a 32-bit classic Wishbone slave and a 100 MHz system clock
package sbg_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [3:0] SBG_ADDR_TX_CTRL = 4'h0;
   localparam logic [3:0] SBG_ADDR_RX_CTRL = 4'h4;
   localparam logic [3:0] SBG_ADDR_DIVIDER = 4'h8;
   localparam logic [3:0] SBG_ADDR_DATA = 4'hC;
   // transmit_status_control field positions
   localparam int SBG_TX_CLK_MASTER = 7;
   localparam int SBG_TX_SYNC_MODE = 4;
   localparam int SBG_TX_HIGH_SPEED = 2;
   // receive_status_control field positions
   localparam int SBG_RX_PINS_EN = 7;
   localparam int SBG_RX_NINE_BIT = 6;
   localparam int SBG_RX_ONE_SHOT = 5;
   localparam int SBG_RX_CONT_EN = 4;
   localparam int SBG_RX_ADDR_EN = 3;
   localparam int SBG_RX_FRAME_ERR = 2;
   localparam int SBG_RX_OVERRUN = 1;
   localparam int SBG_RX_NINTH = 0;
   // reset values
   localparam logic [7:0] SBG_TX_RESET = 8'h00;
   localparam logic [7:0] SBG_RX_RESET = 8'h00;
   localparam logic [7:0] SBG_DIV_RESET = 8'h00;
   // prescale per divider period: sync 4, async high 16, async low 64
   localparam logic [5:0] SBG_PRE_SYNC = 6'h03;
   localparam logic [5:0] SBG_PRE_HIGH = 6'h0F;
   localparam logic [5:0] SBG_PRE_LOW = 6'h3F;
   // receive data word: ninth bit and byte
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
   } sbg_word_t;
endpackage : sbg_pkg

// *** testbench/sbg_peer.sv ***
// remote serial transmitter model on the receive pin and bit clock
// assumes its tasks are called just after a rising edge of clk
`timescale 1ns/100ps
module sbg_peer (
   // system clock
   input wire logic clk,
   // line outputs
   output logic rx_pin,
   output logic ext_bit_clk
);
   // ==========================================================
   // line drivers
   // idle line is high; the clock stands low outside frames
   initial rx_pin = 1'b1;
   initial ext_bit_clk = 1'b0;
   // hold a level for n cycles
   task automatic level(input logic v, input int n);
      rx_pin <= v;
      repeat (n) @(posedge clk);
   endtask : level
   // start low, bits lsb first, stop high
   task automatic send(input logic [7:0] b, input int per);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) level(f[i], per);
   endtask : send
   // n clock pulses, four cycles high then four low
   task automatic clocks(input int n);
      repeat (n) begin
         ext_bit_clk <= 1'b1;
         repeat (4) @(posedge clk);
         ext_bit_clk <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : clocks
endmodule : sbg_peer

// *** testbench/tb_top.sv ***
// self-checking bench for the baud generator and receive front end
// assumes sbg_core and the remote transmitter model sbg_peer
`timescale 1ns/100ps
module tb_top
   import sbg_pkg::*;
;
   // ==========================================================
   // signals and instances
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] dat = 32'h0, rdat, rs = 32'h0178E044;
   logic ack, rx_pin, ext_clk, bit_tick, rx_level, rx_valid, rx_ready = 1'b0;
   sbg_word_t rx_word;
   logic [31:0] rdq[$];
   sbg_word_t wq[$];
   int checks = 0, n_mismatch = 0, ticks = 0;
   always #5 clk = ~clk;
   sbg_core DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rx_pin(rx_pin),
      .ext_bit_clk(ext_clk), .bit_tick(bit_tick), .rx_level(rx_level),
      .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
   sbg_peer peer (.clk(clk), .rx_pin(rx_pin), .ext_bit_clk(ext_clk));
   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // request stands until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rdq.push_back({24'h0, e});
      wb(1'b0, a, 8'h00);
   endtask : rd
   task automatic wait_tick(inout int n);
      do begin
         @(posedge clk);
         n++;
      end while (bit_tick !== 1'b1);
   endtask : wait_tick
   // first tick must not wait out the old count; then one full period
   task automatic per(input logic [7:0] t, input logic [7:0] x, input int p);
      int n;
      wb(1'b1, SBG_ADDR_TX_CTRL, t);
      wb(1'b1, SBG_ADDR_DIVIDER, x);
      n = 2;
      wait_tick(n);
      check(32'(n <= p * (x + 1) + 2), 32'h1);
      n = 0;
      wait_tick(n);
      check(n, p * (x + 1));
   endtask : per
   // ==========================================================
   // watcher: each result takes the oldest note off its queue
   always @(posedge clk) begin
      if (bit_tick === 1'b1) ticks++;
      if (ack === 1'b1 && we === 1'b0) check(rdat, rdq.pop_front());
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
         check(32'(rx_word), 32'(wq.pop_front()));
   end
   // hang guard, well above the expected run length
   initial begin
      #600000;
      n_mismatch++;
      finish_test;
   end
   // ==========================================================
   // main sequence
   initial begin
      int n;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(SBG_ADDR_TX_CTRL, SBG_TX_RESET);
      rd(SBG_ADDR_DIVIDER, SBG_DIV_RESET);
      rd(SBG_ADDR_RX_CTRL, SBG_RX_RESET);
      wb(1'b1, SBG_ADDR_RX_CTRL, 8'h87);
      rd(SBG_ADDR_RX_CTRL, 8'h80);
      wb(1'b1, 4'h2, 8'hFF);
      rd(4'h2, 8'h00);
      // every formula, both divider extremes, random dividers
      per(8'h00, 8'hFF, 64);
      per(8'h04, {4'h0, rs[3:0]}, 16);
      rs = lfsr(rs);
      per(8'h90, {4'h0, rs[3:0]}, 4);
      per(8'h94, {4'h0, rs[7:4]}, 4);
      per(8'h90, 8'h00, 4);
      // slave: divider silent, each external rising edge one tick
      wb(1'b1, SBG_ADDR_TX_CTRL, 8'h10);
      n = ticks;
      repeat (40) @(posedge clk);
      peer.clocks(5);
      repeat (8) @(posedge clk);
      check(ticks - n, 5);
      // overfill the stalled buffer, then drain it
      wb(1'b1, SBG_ADDR_TX_CTRL, 8'h04);
      wb(1'b1, SBG_ADDR_RX_CTRL, 8'h90);
      wb(1'b1, SBG_ADDR_DIVIDER, 8'h07);
      for (int i = 0; i < 3; i++) begin
         rs = lfsr(rs);
         if (i < 2) wq.push_back(sbg_word_t'{1'b0, rs[7:0]});
         peer.send(rs[7:0], 128);
      end
      peer.level(1'b1, 256);
      rd(SBG_ADDR_RX_CTRL, 8'h92);
      rx_ready <= 1'b1;
      repeat (8) @(posedge clk);
      rx_ready <= 1'b0;
      check(wq.size(), 0);
      wb(1'b1, SBG_ADDR_RX_CTRL, 8'h80);
      rd(SBG_ADDR_RX_CTRL, 8'h80);
      // a one-sample glitch is outvoted, a held level wins
      wb(1'b1, SBG_ADDR_TX_CTRL, 8'h90);
      peer.level(1'b0, 40);
      check(rx_level, 1'b0);
      peer.level(1'b1, 4);
      n = 0;
      fork
         peer.level(1'b0, 40);
         repeat (40) @(posedge clk) if (rx_level !== 1'b0) n++;
      join
      check(n, 0);
      peer.level(1'b1, 40);
      check(rx_level, 1'b1);
      finish_test;
   end
endmodule : tb_top
